/* File: addr_filter.sv */
// station address and group hash filter with wishbone register access
// assumes loader and receive byte stream come from logic on clk_i,
// so neither passes a synchroniser
`timescale 1ns/100ps
module addr_filter
  import addr_filter_pkg::*;
#(
  parameter int unsigned WB_ADR_W = ADR_W
)
(
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic [WB_ADR_W-1:0]  wb_adr_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic                 wb_we_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  output logic                      wb_ack_o,
  input  wire ee_load_t             ee_i,
  input  wire logic                 ee_done_i,
  input  wire rx_byte_t             rx_i,
  output filt_result_t              filt_o,
  output logic                      init_done_o
);

  initial
  begin
    if (WB_ADR_W < 7)
      $error("bus address too narrow for the register map");
  end

  filt_state_t s_r;
  filt_state_t s_nxt;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  sel);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        m[b*8 +: 8] = wd[b*8 +: 8];
    return m;
  endfunction

  // reflected crc, bits taken least significant first as on the wire
  function automatic logic [31:0] crc_byte(input logic [31:0] c,
                                           input logic [7:0]  d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++)
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? CRC_POLY : HASH_RST);
    return r;
  endfunction

  function automatic logic hit(input logic [WB_ADR_W-1:0] a,
                               input int unsigned idx);
    return a == WB_ADR_W'(idx * 4);
  endfunction

  logic         req;
  logic         wr;
  logic [31:0]  crc_n;
  logic [47:0]  da_full;
  logic [5:0]   idx;
  logic         tbl_bit;
  logic [31:0]  upper_m;
  logic [63:0]  table_w;

  assign req = wb_cyc_i & wb_stb_i & ~s_r.ack;
  assign wr  = req & wb_we_i;
  assign crc_n = crc_byte(s_r.rx == RX_DA ? s_r.crc : CRC_INIT, rx_i.data);
  // first wire byte sits in bits 7:0, sixth in 47:40
  assign da_full = {rx_i.data, s_r.da};
  assign idx = crc_n[31:26];
  assign tbl_bit = idx[5] ? s_r.hash_hi[idx[4:0]]
                          : s_r.hash_lo[idx[4:0]];
  assign upper_m = merge({16'h0000, s_r.upper}, wb_dat_i, wb_sel_i);
  // flat view of both halves, kept only to cross-check the table pick
  assign table_w = {s_r.hash_hi, s_r.hash_lo};

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = req;
    s_nxt.res.valid = 1'b0;
    s_nxt.rdat = 32'h0000_0000;
    // loader bytes are taken only until loading ends
    if (ee_i.wr && !s_r.init_done)
    begin
      case (ee_i.addr)
        EE_UPPER_LO: s_nxt.upper[7:0] = ee_i.data;
        EE_UPPER_HI: s_nxt.upper[15:8] = ee_i.data;
        default:
        begin
          if (ee_i.addr >= EE_LOWER_FIRST && ee_i.addr <= EE_LOWER_LAST)
            s_nxt.lower[(ee_i.addr - EE_LOWER_FIRST) * 8 +: 8] =
              ee_i.data;
        end
      endcase
    end
    if (ee_done_i)
      s_nxt.init_done = 1'b1;
    // a host write in the same cycle as a loader byte wins
    if (wr)
    begin
      if (hit(wb_adr_i, IDX_UPPER))
        s_nxt.upper = upper_m[15:0];
      if (hit(wb_adr_i, IDX_LOWER))
        s_nxt.lower = merge(s_r.lower, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, IDX_HASH_UPPER))
        s_nxt.hash_hi = merge(s_r.hash_hi, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, IDX_HASH_LOWER))
        s_nxt.hash_lo = merge(s_r.hash_lo, wb_dat_i, wb_sel_i);
      if (hit(wb_adr_i, IDX_CTRL) && wb_sel_i[0])
        s_nxt.pass_all = wb_dat_i[CTRL_PASS_ALL];
    end
    if (req && !wb_we_i)
    begin
      if (hit(wb_adr_i, IDX_UPPER))
        s_nxt.rdat = {16'h0000, s_r.upper};
      else if (hit(wb_adr_i, IDX_LOWER))
        s_nxt.rdat = s_r.lower;
      else if (hit(wb_adr_i, IDX_HASH_UPPER))
        s_nxt.rdat = s_r.hash_hi;
      else if (hit(wb_adr_i, IDX_HASH_LOWER))
        s_nxt.rdat = s_r.hash_lo;
      else if (hit(wb_adr_i, IDX_CTRL))
        s_nxt.rdat[CTRL_PASS_ALL] = s_r.pass_all;
      else if (hit(wb_adr_i, IDX_STATUS))
      begin
        s_nxt.rdat[STAT_INIT_DONE] = s_r.init_done;
        s_nxt.rdat[STAT_RX_BUSY] = s_r.rx == RX_DA;
      end
    end
    // only the six destination bytes are looked at; the rest is skipped
    if (rx_i.valid)
    begin
      case (s_r.rx)
        RX_IDLE:
        begin
          if (rx_i.sof)
          begin
            s_nxt.da[7:0] = rx_i.data;
            s_nxt.cnt = 3'h1;
            s_nxt.crc = crc_n;
            s_nxt.rx = RX_DA;
          end
        end
        RX_DA:
        begin
          if (rx_i.sof)
          begin
            s_nxt.da[7:0] = rx_i.data;
            s_nxt.cnt = 3'h1;
            s_nxt.crc = crc_byte(CRC_INIT, rx_i.data);
          end
          else if (s_r.cnt == DA_LAST)
          begin
            s_nxt.rx = RX_IDLE;
            s_nxt.res.valid = 1'b1;
            s_nxt.res.station_hit =
              da_full == {s_r.upper, s_r.lower};
            s_nxt.res.group = da_full[0];
            s_nxt.res.hash_idx = idx;
            s_nxt.res.accept = da_full[0] &
                               (s_r.pass_all | tbl_bit);
          end
          else
          begin
            s_nxt.da[s_r.cnt * 8 +: 8] = rx_i.data;
            s_nxt.cnt = s_r.cnt + 3'h1;
            s_nxt.crc = crc_n;
          end
        end
        default: s_nxt.rx = RX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      s_r <= '0;
      s_r.upper <= UPPER_RST;
      s_r.lower <= LOWER_RST;
      s_r.hash_hi <= HASH_RST;
      s_r.hash_lo <= HASH_RST;
      s_r.crc <= CRC_INIT;
      s_r.rx <= RX_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  assign wb_ack_o = s_r.ack;
  assign wb_dat_o = s_r.rdat;
  assign filt_o = s_r.res;
  assign init_done_o = s_r.init_done;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_last_byte;
    rx_i.valid && !rx_i.sof && s_r.rx == RX_DA && s_r.cnt == DA_LAST;
  endsequence

  sequence s_host_wr(int unsigned i);
    wr && hit(wb_adr_i, i) && wb_sel_i == 4'hF;
  endsequence

  property p_ack;
    req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not one cycle");

  property p_upper_read;
    wb_ack_o && !$past(wb_we_i) && hit($past(wb_adr_i), IDX_UPPER)
      |-> wb_dat_o[31:16] == 16'h0000;
  endproperty
  a_upper_read: assert property (p_upper_read)
    else $error("upper reserved bits not zero");

  property p_ee_upper;
    ee_i.wr && !s_r.init_done && !wr && ee_i.addr == EE_UPPER_HI
      |=> s_r.upper[15:8] == $past(ee_i.data);
  endproperty
  a_ee_upper: assert property (p_ee_upper)
    else $error("loader byte 6 not in upper 15:8");

  property p_ee_lower;
    ee_i.wr && !s_r.init_done && !wr && ee_i.addr == EE_LOWER_LAST
      |=> s_r.lower[31:24] == $past(ee_i.data);
  endproperty
  a_ee_lower: assert property (p_ee_lower)
    else $error("loader byte 4 not in lower 31:24");

  property p_ee_upper_lo;
    ee_i.wr && !s_r.init_done && !wr && ee_i.addr == EE_UPPER_LO
      |=> s_r.upper[7:0] == $past(ee_i.data);
  endproperty
  a_ee_upper_lo: assert property (p_ee_upper_lo)
    else $error("loader byte 5 not in upper 7:0");

  property p_ee_lower_first;
    ee_i.wr && !s_r.init_done && !wr && ee_i.addr == EE_LOWER_FIRST
      |=> s_r.lower[7:0] == $past(ee_i.data);
  endproperty
  a_ee_lower_first: assert property (p_ee_lower_first)
    else $error("loader byte 1 not in lower 7:0");

  property p_upper_wr;
    s_host_wr(IDX_UPPER)
      |=> {16'h0000, s_r.upper} == ($past(wb_dat_i) & 32'h0000_FFFF);
  endproperty
  a_upper_wr: assert property (p_upper_wr)
    else $error("upper write not confined to bits 15:0");

  property p_station;
    s_last_byte |=> filt_o.valid && filt_o.station_hit ==
      ($past(da_full) == {$past(s_r.upper), $past(s_r.lower)});
  endproperty
  a_station: assert property (p_station)
    else $error("station compare wrong");

  property p_hash_idx;
    s_last_byte |=> filt_o.hash_idx == $past(crc_n[31:26]);
  endproperty
  a_hash_idx: assert property (p_hash_idx)
    else $error("hash index not crc top bits");

  property p_accept;
    s_last_byte |=> filt_o.accept == ($past(da_full[0]) &&
      ($past(s_r.pass_all) || $past(tbl_bit)));
  endproperty
  a_accept: assert property (p_accept)
    else $error("group accept wrong");

  property p_group_only;
    s_last_byte ##0 !da_full[0] |=> !filt_o.accept;
  endproperty
  a_group_only: assert property (p_group_only)
    else $error("individual address passed the group filter");

  property p_table_bit;
    s_last_byte |-> tbl_bit == table_w[idx];
  endproperty
  a_table_bit: assert property (p_table_bit)
    else $error("hash table bit not picked by the index");

  property p_pass_all;
    s_last_byte ##0 (s_r.pass_all && da_full[0]) |=> filt_o.accept;
  endproperty
  a_pass_all: assert property (p_pass_all)
    else $error("pass all ignored");

  property p_hash_wr;
    s_host_wr(IDX_HASH_UPPER) |=> s_r.hash_hi == $past(wb_dat_i);
  endproperty
  a_hash_wr: assert property (p_hash_wr)
    else $error("upper hash write lost");

  property p_keep;
    !wr && !(ee_i.wr && !s_r.init_done)
      |=> $stable(s_r.upper) && $stable(s_r.lower);
  endproperty
  a_keep: assert property (p_keep)
    else $error("address changed without a write");
endmodule

/* File: addr_filter_pkg.sv */
// constants, types and carriers of the station address and group hash filter
// assumes a 20 MHz single clock and a classic wishbone slave port
// Overview of operation
// - upper address register holds address 47:32 in bits 15:0, rest zero
// - loader bytes 0x05 and 0x06 fill upper register bits 7:0, 15:8
// - loader bytes 0x01 to 0x04 fill lower register, 0x01 lowest
// - first received byte matches lower 7:0, sixth matches upper 15:8
// - address bits 7:0 go first on the wire, bits 47:40 last
// - upper address register resets to 0000FFFFh
// - lower address register resets to the printed default 0FFFFFFFh
// - both hash table registers reset to zero
// - destination address yields a hash index picking one table bit
// - index top bit picks upper or lower register, five bits pick bit
// - position 00000 low is bit 0, 11111 high is bit 31
// - group frame accepted when its table bit is 1, else rejected
// - accept every group frame when the pass-all control is set
// - upper hash register holds table bits 63:32, lower holds 31:0
package addr_filter_pkg;
  localparam int unsigned  ADR_W           = 8;
  localparam int unsigned  IDX_UPPER       = 2;
  localparam int unsigned  IDX_LOWER       = 3;
  localparam int unsigned  IDX_HASH_UPPER  = 4;
  localparam int unsigned  IDX_HASH_LOWER  = 5;
  localparam int unsigned  IDX_CTRL        = 16;
  localparam int unsigned  IDX_STATUS      = 17;
  localparam logic [15:0]  UPPER_RST       = 16'hFFFF;
  localparam logic [31:0]  LOWER_RST       = 32'h0FFF_FFFF;
  localparam logic [31:0]  HASH_RST        = 32'h0000_0000;
  localparam logic [31:0]  CRC_INIT        = 32'hFFFF_FFFF;
  localparam logic [31:0]  CRC_POLY        = 32'hEDB8_8320;
  localparam logic [7:0]   EE_LOWER_FIRST  = 8'h01;
  localparam logic [7:0]   EE_LOWER_LAST   = 8'h04;
  localparam logic [7:0]   EE_UPPER_LO     = 8'h05;
  localparam logic [7:0]   EE_UPPER_HI     = 8'h06;
  localparam logic [2:0]   DA_LAST         = 3'h5;
  localparam int unsigned  CTRL_PASS_ALL   = 0;
  localparam int unsigned  STAT_INIT_DONE  = 0;
  localparam int unsigned  STAT_RX_BUSY    = 1;

  typedef enum logic {RX_IDLE, RX_DA} rx_state_t;

  typedef struct packed {
    logic        wr;
    logic [7:0]  addr;
    logic [7:0]  data;
  } ee_load_t;

  typedef struct packed {
    logic        valid;
    logic        sof;
    logic [7:0]  data;
  } rx_byte_t;

  typedef struct packed {
    logic        valid;
    logic        station_hit;
    logic        group;
    logic        accept;
    logic [5:0]  hash_idx;
  } filt_result_t;

  typedef struct packed {
    logic [15:0]   upper;
    logic [31:0]   lower;
    logic [31:0]   hash_hi;
    logic [31:0]   hash_lo;
    logic          pass_all;
    logic          init_done;
    logic          ack;
    logic [31:0]   rdat;
    rx_state_t     rx;
    logic [2:0]    cnt;
    logic [31:0]   crc;
    logic [39:0]   da;
    filt_result_t  res;
  } filt_state_t;
endpackage

/* File: addr_filter_tb.sv */
// self-checking bench of the address filter: registers, loader, frames
// assumes rx_loader_model stands in for the loader and receive path
`timescale 1ns/100ps
module addr_filter_tb
  import addr_filter_pkg::*;
;
  logic         clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i;
  logic         wb_ack_o, init_done_o, ee_done_i, pa;
  logic [7:0]   wb_adr_i, b;
  logic [3:0]   wb_sel_i;
  logic [31:0]  wb_dat_i, wb_dat_o, lo, hh, hl, r1;
  logic [31:0]  seed = 32'hE6A8;
  logic [15:0]  up;
  logic [47:0]  da;
  ee_load_t     ee_i;
  rx_byte_t     rx_i;
  filt_result_t filt_o;
  logic [31:0]  rq[$];
  logic [8:0]   fq[$];
  int           num_errors, checks_done;

  addr_filter dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .ee_i(ee_i), .ee_done_i(ee_done_i),
    .rx_i(rx_i), .filt_o(filt_o), .init_done_o(init_done_o));
  rx_loader_model src (.clk_i(clk_i), .ee_o(ee_i), .ee_done_o(ee_done_i),
    .rx_o(rx_i));

  initial
  begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected {hit, group, accept, index} worked out from the shadow copy
  function automatic logic [8:0] fexp(input logic [47:0] d);
    logic [31:0] c;
    logic [63:0] t;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++)
      c = (c >> 1) ^ ((c[0] ^ d[i]) ? CRC_POLY : 32'h0);
    t = {hh, hl};
    return {d == {up, lo}, d[0], d[0] & (pa | t[c[31:26]]), c[31:26]};
  endfunction

  task automatic chk(input string n, input logic [31:0] s, e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report();
    num_errors += rq.size() + fq.size();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    input logic [31:0] e);
    if (!w)
      rq.push_back(e);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic frame(input logic [47:0] d);
    fq.push_back(fexp(d));
    src.send(d);
  endtask

  always @(posedge clk_i)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk("read data", wb_dat_o, rq.pop_front());
    if (filt_o.valid === 1'b1)
      chk("filter", {23'h0, filt_o[8:0]}, {23'h0, fq.pop_front()});
  end

  initial
  begin
    repeat (20000) @(posedge clk_i);
    num_errors++;
    final_report();
  end

  initial
  begin
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = '0;
    up = 16'hFFFF;
    lo = 32'h0FFF_FFFF;
    hh = 32'h0;
    hl = 32'h0;
    pa = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h08, 32'h0, 4'hF, 32'h0000_FFFF);
    wb(1'b0, 8'h0C, 32'h0, 4'hF, 32'h0FFF_FFFF);
    wb(1'b0, 8'h10, 32'h0, 4'hF, 32'h0);
    wb(1'b0, 8'h14, 32'h0, 4'hF, 32'h0);
    wb(1'b0, 8'h80, 32'h0, 4'hF, 32'h0);
    frame({up, lo});
    chk("init done", {31'h0, init_done_o}, 32'h0);
    for (int i = 1; i <= 6; i++)
    begin
      r1 = rnd();
      b = r1[7:0];
      if (i < 5)
        lo[8*(i-1)+:8] = b;
      else
        up[8*(i-5)+:8] = b;
      src.load(i[7:0], b);
    end
    src.done();
    src.load(8'h01, ~lo[7:0]);
    chk("init done", {31'h0, init_done_o}, 32'h1);
    wb(1'b0, 8'h44, 32'h0, 4'hF, 32'h1);
    wb(1'b0, 8'h0C, 32'h0, 4'hF, lo);
    wb(1'b0, 8'h08, 32'h0, 4'hF, {16'h0, up});
    frame({up, lo});
    // host writes only once loading has ended
    wb(1'b1, 8'h08, 32'hFFFF_1234, 4'hF, 32'h0);
    up = 16'h1234;
    wb(1'b0, 8'h08, 32'h0, 4'hF, 32'h0000_1234);
    for (int k = 0; k < 48; k++)
    begin
      if (k % 8 == 0)
      begin
        hh = rnd();
        hl = rnd();
        pa = (k >= 32);
        wb(1'b1, 8'h10, hh, 4'hF, 32'h0);
        wb(1'b1, 8'h14, hl, 4'hF, 32'h0);
        wb(1'b1, 8'h40, {31'h0, pa}, 4'hF, 32'h0);
      end
      r1 = rnd();
      da = {r1[15:0], rnd()};
      if (k % 4 == 1)
        da = {up, lo};
      frame(da);
    end
    wb(1'b1, 8'h14, 32'hFFFF_FFFF, 4'hF, 32'h0);
    wb(1'b1, 8'h14, 32'h0, 4'h5, 32'h0);
    wb(1'b0, 8'h14, 32'h0, 4'hF, 32'hFF00_FF00);
    repeat (4) @(posedge clk_i);
    final_report();
  end
endmodule

/* File: rx_loader_model.sv */
// power-on byte loader and receive byte source facing the address filter
// assumes the filter samples both streams on the rising edge of clk_i
`timescale 1ns/100ps
module rx_loader_model
  import addr_filter_pkg::*;
(
  input  wire logic clk_i,
  output ee_load_t  ee_o,
  output logic      ee_done_o,
  output rx_byte_t  rx_o
);
  initial
  begin
    ee_o = '0;
    ee_done_o = 1'b0;
    rx_o = '0;
  end
  // released lines show inverted data so stale bytes never look valid
  task automatic load(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    ee_o <= '{wr: 1'b1, addr: a, data: d};
    @(posedge clk_i);
    ee_o <= '{wr: 1'b0, addr: ~a, data: ~d};
  endtask
  task automatic done();
    @(posedge clk_i);
    ee_done_o <= 1'b1;
    @(posedge clk_i);
    ee_done_o <= 1'b0;
  endtask
  // address bits 7:0 go out first, back to back
  task automatic send(input logic [47:0] da);
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk_i);
      rx_o <= '{valid: 1'b1, sof: (i == 0), data: da[8*i+:8]};
    end
    @(posedge clk_i);
    rx_o <= '{valid: 1'b0, sof: 1'b0, data: ~da[47:40]};
  endtask
endmodule
